// *** design/gptc_pkg.sv ***
// Package with register map, field positions and timing constants.
package gptc_pkg;
    localparam logic [7:0] GPTC_OFF_CTRL = 8'h12;
    localparam logic [7:0] GPTC_OFF_GP_HI = 8'h13;
    localparam logic [7:0] GPTC_OFF_GP_LO = 8'h14;
    localparam logic [7:0] GPTC_OFF_NR_HI = 8'h10;
    localparam logic [7:0] GPTC_OFF_NR_LO = 8'h11;
    localparam logic [7:0] GPTC_OFF_STATUS = 8'h40;
    localparam logic [7:0] GPTC_CTRL_RESET = 8'h00;
    localparam logic [7:0] GPTC_CTRL_WMASK = 8'hef;
    localparam int GPTC_TRIG_HI = 7;
    localparam int GPTC_TRIG_LO = 5;
    localparam int GPTC_MRT_STEP_BIT = 3;
    localparam int GPTC_NRT_PEER_BIT = 2;
    localparam int GPTC_NRT_PAY_BIT = 1;
    localparam int GPTC_NRT_STEP_BIT = 0;
    localparam logic [2:0] GPTC_TRIG_NONE = 3'h0;
    localparam logic [2:0] GPTC_TRIG_RX_END = 3'h1;
    localparam logic [2:0] GPTC_TRIG_RX_START = 3'h2;
    localparam logic [2:0] GPTC_TRIG_TX_END = 3'h3;
    localparam int GPTC_GP_STEP_FC = 8;
    localparam int GPTC_MRT_STEP_SMALL_FC = 64;
    localparam int GPTC_MRT_STEP_LARGE_FC = 512;
    localparam int GPTC_NRT_STEP_SMALL_FC = 64;
    localparam int GPTC_NRT_STEP_LARGE_FC = 4096;
endpackage

// *** design/gptc_tick_if.sv ***
// Interface carrying the carrier-tick enable and counter controls.
`timescale 1ns/1ps
`default_nettype none
interface gptc_tick_if;
    logic fc_tick;
    logic start;
    logic [15:0] load_value;
    logic expired;
    logic running;
    modport ctrl (output start, output load_value, output fc_tick,
        input expired, input running);
    modport cnt (input start, input load_value, input fc_tick,
        output expired, output running);
endinterface
`default_nettype wire

// *** design/gptc_counter.sv ***
// General purpose down counter stepping every eight carrier periods.
`timescale 1ns/1ps
`default_nettype none
module gptc_counter
    import gptc_pkg::*;
#(
    parameter int STEP_FC = GPTC_GP_STEP_FC
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Control from the main block.
    gptc_tick_if.cnt tif
);
    logic [15:0] count_q;
    logic [15:0] step_q;
    logic run_q;
    logic exp_q;

    // A start while running reloads; expiry fires once.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            step_q <= 16'h0000;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            exp_q <= 1'b0;
            if (tif.start) begin
                count_q <= tif.load_value;
                step_q <= 16'h0000;
                run_q <= (tif.load_value != 16'h0000);
                exp_q <= (tif.load_value == 16'h0000);
            end else if (run_q && tif.fc_tick) begin
                if (step_q == 16'(STEP_FC - 1)) begin
                    step_q <= 16'h0000;
                    if (count_q == 16'h0001) begin
                        run_q <= 1'b0;
                        exp_q <= 1'b1;
                    end
                    count_q <= count_q - 16'h0001;
                end else begin
                    step_q <= step_q + 16'h0001;
                end
            end
        end
    end

    assign tif.expired = exp_q;
    assign tif.running = run_q;

    a_expiry_stops: assert property (@(posedge core_clk) disable iff (!rst_n)
        tif.expired |-> !run_q) else $error("expiry while running");
endmodule
`default_nettype wire

// *** design/gptc_top.sv ***
// Timer trigger control: register file, trigger select, step selection.
//
// Notes on behaviour
// - Bits 7:5 choose extra timer trigger.
// - Direct command always starts the timer.
// - Code zero: command start only.
// - Code 001: also start at receive end.
// - Code 010: also start at receive start.
// - Code 011: also start at transmit end.
// - Peer mode, 011: expiry drops own field.
// - Peer mode, 011: enables no-response start.
// - Bit 3 picks mask step 64/512.
// - Bit 2 picks no-response start event.
// - Bit 1 selects payment-compliance mode.
// - Bit 0 picks no-response step 64/4096.
// - Sixteen-bit timeout in eight-period steps.
// - Timeout span one step to 38.7ms.
// - No-response timer starts after transmit end.
// - Mask step chosen by mask step bit.
// - Zero no-response value never starts timer.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gptc_top
    import gptc_pkg::*;
#(
    parameter int CLK_PER_FC_TICK = 1
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Protocol events, one-cycle pulses on core_clk, and the peer mode level.
    input wire logic cmd_start_gp,
    input wire logic rx_end_evt,
    input wire logic rx_start_evt,
    input wire logic tx_end_evt,
    input wire logic peer_field_on_evt,
    input wire logic active_peer_mode,
    // Outputs toward field and sibling timers.
    output logic gp_expired,
    output logic field_off_req,
    output logic nrt_start,
    output logic nrt_payment_mode,
    output logic [12:0] mrt_step_fc,
    output logic [12:0] nrt_step_fc
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] gp_hi_q;
    logic [7:0] gp_lo_q;
    logic [7:0] nr_hi_q;
    logic [7:0] nr_lo_q;
    logic [7:0] rdata_q;
    logic [2:0] trig_sel;
    logic gp_start;
    logic tick_q;
    logic [15:0] div_q;
    logic fo_q;
    logic ns_q;
    logic [7:0] rd_mux;
    gptc_tick_if tif ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // General purpose timeout bytes have no defined reset value, so they are not reset.
    always_ff @(posedge core_clk) begin
        if (reg_wr && hit(reg_addr, GPTC_OFF_GP_HI)) begin
            gp_hi_q <= reg_wdata;
        end
        if (reg_wr && hit(reg_addr, GPTC_OFF_GP_LO)) begin
            gp_lo_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q <= GPTC_CTRL_RESET;
            nr_hi_q <= 8'h00;
            nr_lo_q <= 8'h00;
        end else begin
            if (reg_wr && hit(reg_addr, GPTC_OFF_CTRL)) begin
                ctrl_q <= reg_wdata & GPTC_CTRL_WMASK;
            end
            if (reg_wr && hit(reg_addr, GPTC_OFF_NR_HI)) begin
                nr_hi_q <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, GPTC_OFF_NR_LO)) begin
                nr_lo_q <= reg_wdata;
            end
        end
    end

    always_comb begin
        case (reg_addr)
            GPTC_OFF_CTRL: rd_mux = ctrl_q;
            GPTC_OFF_GP_HI: rd_mux = gp_hi_q;
            GPTC_OFF_GP_LO: rd_mux = gp_lo_q;
            GPTC_OFF_NR_HI: rd_mux = nr_hi_q;
            GPTC_OFF_NR_LO: rd_mux = nr_lo_q;
            GPTC_OFF_STATUS: rd_mux = {7'h00, tif.running};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    assign trig_sel = ctrl_q[GPTC_TRIG_HI:GPTC_TRIG_LO];

    always_comb begin
        gp_start = cmd_start_gp;
        case (trig_sel)
            GPTC_TRIG_NONE: gp_start = cmd_start_gp;
            GPTC_TRIG_RX_END: gp_start = cmd_start_gp | rx_end_evt;
            GPTC_TRIG_RX_START: gp_start = cmd_start_gp | rx_start_evt;
            GPTC_TRIG_TX_END: gp_start = cmd_start_gp | tx_end_evt;
            default: gp_start = cmd_start_gp;
        endcase
    end

    // Carrier tick enable; one tick every CLK_PER_FC_TICK core cycles stands for one period.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (div_q == 16'(CLK_PER_FC_TICK - 1)) begin
            div_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    assign tif.fc_tick = tick_q;
    assign tif.start = gp_start;
    assign tif.load_value = {gp_hi_q, gp_lo_q};

    gptc_counter #(.STEP_FC(GPTC_GP_STEP_FC)) u_cnt (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tif(tif)
    );

    assign gp_expired = tif.expired;

    // ------------------------------------------------------------
    // Peer mode field and no-response start
    // ------------------------------------------------------------
    logic peer_tx;
    logic nr_nonzero;
    logic nr_evt;
    assign peer_tx = active_peer_mode && (trig_sel == GPTC_TRIG_TX_END);
    assign nr_nonzero = {nr_hi_q, nr_lo_q} != 16'h0000;

    always_comb begin
        if (peer_tx) begin
            nr_evt = ctrl_q[GPTC_NRT_PEER_BIT] ? peer_field_on_evt
                : tif.expired;
        end else begin
            nr_evt = tx_end_evt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fo_q <= 1'b0;
            ns_q <= 1'b0;
        end else begin
            fo_q <= peer_tx && tif.expired;
            ns_q <= nr_evt && nr_nonzero;
        end
    end
    assign field_off_req = fo_q;
    assign nrt_start = ns_q;

    // ------------------------------------------------------------
    // Step selection
    // ------------------------------------------------------------
    assign nrt_payment_mode = ctrl_q[GPTC_NRT_PAY_BIT];
    assign mrt_step_fc = ctrl_q[GPTC_MRT_STEP_BIT]
        ? 13'(GPTC_MRT_STEP_LARGE_FC) : 13'(GPTC_MRT_STEP_SMALL_FC);
    assign nrt_step_fc = ctrl_q[GPTC_NRT_STEP_BIT]
        ? 13'(GPTC_NRT_STEP_LARGE_FC) : 13'(GPTC_NRT_STEP_SMALL_FC);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_cmd_starts: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmd_start_gp |-> gp_start) else $error("command lost");
    a_rsvd_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_q[4] == 1'b0) else $error("reserved bit set");
    a_none_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trig_sel == 3'h0 && !cmd_start_gp) |-> !gp_start)
        else $error("extra start");
    a_rx_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trig_sel == 3'h1 && rx_end_evt) |-> gp_start)
        else $error("rx end trigger");
    a_rx_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trig_sel == 3'h2 && rx_start_evt) |-> gp_start)
        else $error("rx start trigger");
    a_tx_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trig_sel == 3'h3 && tx_end_evt) |-> gp_start)
        else $error("tx end trigger");
    a_field_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        (peer_tx && gp_expired) |=> field_off_req)
        else $error("field not dropped");
    a_nrt_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        nrt_start |-> $past(nr_nonzero)) else $error("zero nrt start");
    a_mrt_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        mrt_step_fc == (ctrl_q[3] ? 13'd512 : 13'd64))
        else $error("mask step");
    a_nrt_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        nrt_step_fc == (ctrl_q[0] ? 13'd4096 : 13'd64))
        else $error("nrt step");
    a_ctrl_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h12) |=> ctrl_q == ($past(reg_wdata) & 8'hef))
        else $error("ctrl write");
    a_pay_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        nrt_payment_mode == ctrl_q[1]) else $error("pay mode");
    a_peer_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        (peer_tx && ctrl_q[2] && peer_field_on_evt && nr_nonzero)
        |=> nrt_start) else $error("peer nrt start");
    a_expiry_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tif.start && tif.load_value == 16'h0001) |-> ##[1:40] gp_expired)
        else $error("short timeout");
    a_read_ctrl: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == 8'h12) |=> reg_rdata == $past(ctrl_q))
        else $error("ctrl read");

    // Reserved codes must behave exactly like code zero.
    a_rsvd_codes: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trig_sel[2] && !cmd_start_gp) |-> !gp_start)
        else $error("reserved code start");
    a_rx_end_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trig_sel == 3'h1 && !cmd_start_gp && !rx_end_evt) |-> !gp_start)
        else $error("stray rx end start");
    a_rx_start_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trig_sel == 3'h2 && !cmd_start_gp && !rx_start_evt) |-> !gp_start)
        else $error("stray rx start start");
    a_tx_end_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        (trig_sel == 3'h3 && !cmd_start_gp && !tx_end_evt) |-> !gp_start)
        else $error("stray tx end start");

    // Outside peer code 011 the no-response timer follows transmit end.
    a_nrt_tx_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!peer_tx && tx_end_evt && nr_nonzero) |=> nrt_start)
        else $error("nrt tx end start");
    a_nrt_expiry: assert property (@(posedge core_clk) disable iff (!rst_n)
        (peer_tx && !ctrl_q[2] && gp_expired && nr_nonzero) |=> nrt_start)
        else $error("nrt field off start");
    a_nrt_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (peer_tx && !(ctrl_q[2] ? peer_field_on_evt : gp_expired))
        |=> !nrt_start) else $error("peer nrt stray");
    a_field_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(peer_tx && gp_expired) |=> !field_off_req)
        else $error("stray field off");

    // A start either arms the counter or, for a zero load, expires at once.
    a_start_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
        tif.start |=> (tif.running || gp_expired))
        else $error("start not taken");
    a_gp_hi_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == GPTC_OFF_GP_HI)
        |=> gp_hi_q == $past(reg_wdata)) else $error("gp hi write");
    a_gp_lo_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == GPTC_OFF_GP_LO)
        |=> gp_lo_q == $past(reg_wdata)) else $error("gp lo write");
    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00) else $error("read data idle");

    c_cmd: cover property (@(posedge core_clk) cmd_start_gp ##[1:50] gp_expired);
    c_tx: cover property (@(posedge core_clk) trig_sel == 3'h3 && tx_end_evt);
    c_fo: cover property (@(posedge core_clk) field_off_req);
    c_nrt: cover property (@(posedge core_clk) nrt_start);
    c_peer: cover property (@(posedge core_clk) peer_tx && peer_field_on_evt);
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking testbench for the timer trigger control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gptc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic cmd_go;
    logic rx_end;
    logic rx_start;
    logic tx_end;
    logic peer_on;
    logic act_peer;
    logic [7:0] reg_rdata;
    logic gp_expired, field_off_req, nrt_start, nrt_payment_mode;
    logic [12:0] mrt_step_fc, nrt_step_fc;
    logic rd_seen = 1'b0;
    logic [7:0] rd_q[$];
    logic [2:0] ev_q[$];
    logic [7:0] d;
    logic fire;
    int checks = 0;
    int miscompares = 0;
    integer seed = 32'h0357;

    always #20 core_clk = ~core_clk;

    gptc_top #(.CLK_PER_FC_TICK(1)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_start_gp(cmd_go), .rx_end_evt(rx_end),
        .rx_start_evt(rx_start), .tx_end_evt(tx_end),
        .peer_field_on_evt(peer_on), .active_peer_mode(act_peer),
        .gp_expired(gp_expired), .field_off_req(field_off_req),
        .nrt_start(nrt_start), .nrt_payment_mode(nrt_payment_mode),
        .mrt_step_fc(mrt_step_fc), .nrt_step_fc(nrt_step_fc)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic pulse(input int k);
        {peer_on, tx_end, rx_start, rx_end, cmd_go} <= 5'h01 << k;
        @(posedge core_clk);
        {peer_on, tx_end, rx_start, rx_end, cmd_go} <= 5'h00;
    endtask

    // Counts edges from the start edge to the expiry pulse.
    task automatic wait_gp(input int n, input logic go);
        int k;
        k = 0;
        while (gp_expired !== 1'b1 && k < 8 * n + 4) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        if (go) begin
            check("gp delay", 16'(k), 16'(8 * n));
            if (k == 8 * n + 4) begin
                final_report();
            end
        end else begin
            check("gp idle", 16'(k), 16'(8 * n + 4));
        end
        @(posedge core_clk);
    endtask

    task automatic drain();
        int k;
        k = 0;
        while (ev_q.size() != 0 && k < 40) begin
            @(posedge core_clk);
            k++;
        end
        if (ev_q.size() != 0) begin
            check("event wait", 1'b1, 1'b0);
            final_report();
        end
        @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------
    // Read data only stands in the cycle after the strobe.
    always @(posedge core_clk) begin
        if (rd_seen) begin
            if (rd_q.size() == 0) begin
                check("rd queue", 1'b1, 1'b0);
            end else begin
                check("reg_rdata", reg_rdata, rd_q.pop_front());
            end
        end
        rd_seen <= reg_rd;
        if (gp_expired || field_off_req || nrt_start) begin
            if (ev_q.size() == 0) begin
                check("event", {field_off_req, nrt_start, gp_expired}, 3'h0);
            end else begin
                check("event", {field_off_req, nrt_start, gp_expired}, ev_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n <= 1'b0;
        reg_addr <= 8'h00;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        act_peer <= 1'b0;
        {peer_on, tx_end, rx_start, rx_end, cmd_go} <= 5'h00;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        reg_read(GPTC_OFF_CTRL, 8'h00);
        reg_read(GPTC_OFF_STATUS, 8'h00);
        check("mrt step rst", mrt_step_fc, 13'h0040);
        reg_write(8'h20, 8'h5a);
        reg_read(8'h20, 8'h00);
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            reg_write(GPTC_OFF_CTRL, d);
            reg_read(GPTC_OFF_CTRL, d & 8'hef);
            check("mrt step", mrt_step_fc, d[3] ? 13'h0200 : 13'h0040);
            check("nrt step", nrt_step_fc, d[0] ? 13'h1000 : 13'h0040);
            check("pay mode", nrt_payment_mode, d[1]);
            d = 8'($random(seed));
            reg_write(GPTC_OFF_GP_HI, d);
            reg_write(GPTC_OFF_GP_LO, ~d);
            reg_read(GPTC_OFF_GP_HI, d);
            reg_read(GPTC_OFF_GP_LO, ~d);
        end
        $display("test registers done");
        reg_write(GPTC_OFF_GP_HI, 8'h00);
        reg_write(GPTC_OFF_GP_LO, 8'h03);
        reg_write(GPTC_OFF_NR_HI, 8'h00);
        reg_write(GPTC_OFF_NR_LO, 8'h00);
        for (int c = 0; c < 8; c++) begin
            reg_write(GPTC_OFF_CTRL, {c[2:0], 5'h00});
            for (int e = 0; e < 4; e++) begin
                fire = (e == 0) || (c == e);
                if (fire) begin
                    ev_q.push_back(3'b001);
                end
                pulse(e);
                wait_gp(3, fire);
            end
        end
        $display("test trigger select done");
        reg_write(GPTC_OFF_CTRL, 8'h00);
        ev_q.push_back(3'b001);
        pulse(0);
        reg_read(GPTC_OFF_STATUS, 8'h01);
        repeat (8) @(posedge core_clk);
        pulse(0);
        wait_gp(3, 1'b1);
        reg_write(GPTC_OFF_GP_LO, 8'h01);
        ev_q.push_back(3'b001);
        pulse(0);
        wait_gp(1, 1'b1);
        reg_write(GPTC_OFF_GP_LO, 8'h03);
        $display("test restart done");
        act_peer <= 1'b1;
        reg_write(GPTC_OFF_NR_LO, 8'h05);
        reg_read(GPTC_OFF_NR_LO, 8'h05);
        reg_write(GPTC_OFF_CTRL, 8'h60);
        ev_q.push_back(3'b001);
        ev_q.push_back(3'b110);
        pulse(3);
        wait_gp(3, 1'b1);
        drain();
        reg_write(GPTC_OFF_CTRL, 8'h64);
        ev_q.push_back(3'b001);
        ev_q.push_back(3'b100);
        ev_q.push_back(3'b010);
        pulse(3);
        wait_gp(3, 1'b1);
        pulse(4);
        drain();
        $display("test peer mode done");
        act_peer <= 1'b0;
        reg_write(GPTC_OFF_CTRL, 8'h00);
        ev_q.push_back(3'b010);
        pulse(3);
        drain();
        reg_write(GPTC_OFF_NR_LO, 8'h00);
        pulse(3);
        repeat (4) @(posedge core_clk);
        $display("test no-response start done");
        final_report();
    end
endmodule
`default_nettype wire
